// ===== core/i2cis_regs.svh
// Purpose: Offsets, field positions and reset values of the status block
// Assumes: Byte addresses on an 8-bit APB address
// Notes: Definitions only
`ifndef I2CIS_REGS_SVH
`define I2CIS_REGS_SVH
`define I2CIS_OFS_MASKED 8'h2C
`define I2CIS_OFS_MASK 8'h30
`define I2CIS_OFS_RAW 8'h34
`define I2CIS_OFS_RX_TRIGGER_FIELD 8'h38
`define I2CIS_OFS_TX_TRIGGER_FIELD 8'h3C
`define I2CIS_OFS_CLR_ALL 8'h40
`define I2CIS_OFS_CLR_RXU 8'h44
`define I2CIS_OFS_CLR_RXO 8'h48
`define I2CIS_OFS_CLR_TXO 8'h4C
`define I2CIS_OFS_CLR_RDR 8'h50
`define I2CIS_OFS_CLR_ABT 8'h54
`define I2CIS_OFS_CLR_RXD 8'h58
`define I2CIS_OFS_CLR_ACT 8'h5C
`define I2CIS_OFS_CLR_STP 8'h60
`define I2CIS_OFS_CLR_STA 8'h64
`define I2CIS_OFS_CLR_GC 8'h68
`define I2CIS_OFS_ABT_SRC 8'h80
`define I2CIS_B_GC 11
`define I2CIS_B_STA 10
`define I2CIS_B_STP 9
`define I2CIS_B_ACT 8
`define I2CIS_B_RXD 7
`define I2CIS_B_ABT 6
`define I2CIS_B_RDR 5
`define I2CIS_B_TXE 4
`define I2CIS_B_TXO 3
`define I2CIS_B_RXF 2
`define I2CIS_B_RXO 1
`define I2CIS_B_RXU 0
`define I2CIS_NFLAGS 12
`define I2CIS_MASK_RST 12'h8FF
`define I2CIS_TL_RST 4'h7
`define I2CIS_TL_MAX 4'hF
`endif

// ===== core/i2cis_pkg.sv
// Purpose: Types shared by the interrupt status block
// Assumes: Nothing
// Notes: Constants live in i2cis_regs.svh
package i2cis_pkg;
  typedef logic [4:0] i2cis_level_t;
  typedef logic [11:0] i2cis_flags_t;
  typedef enum logic [1:0] {
    ST_RUN = 2'b00,
    ST_DRAIN = 2'b01,
    ST_OFF = 2'b10
  } i2cis_state_t;
endpackage

// ===== core/i2cis_bus_if.sv
// Purpose: Decoded register access between bus front and core
// Assumes: One clock domain
// Notes: acc pulses on the completing APB edge
`timescale 1ns/10ps
interface i2cis_bus_if;
  logic acc;
  logic wr;
  logic [7:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  logic hit;
  modport front (output acc, output wr, output addr, output wdata,
                 input rdata, input hit);
  modport core (input acc, input wr, input addr, input wdata,
                output rdata, output hit);
endinterface

// ===== core/i2cis_apb_front.sv
// Purpose: APB slave front, one wait-free access cycle
// Assumes: Master keeps request stable until pready
// Notes: Read data sampled in the setup cycle
`timescale 1ns/10ps
module i2cis_apb_front (
  input logic pclk,
  input logic presetn,
  input logic pclk_en,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  i2cis_bus_if.front bus
);
  logic setup;
  assign setup = psel & ~penable & ~pready;
  assign bus.acc = psel & penable & pready & pclk_en;
  assign bus.wr = pwrite;
  assign bus.addr = paddr;
  assign bus.wdata = pwdata;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (pclk_en) begin
      pready <= setup;
      prdata <= (setup & ~pwrite) ? bus.rdata : 32'h00000000;
      pslverr <= setup & ~bus.hit;
    end
  end

  a_ready_one_cycle: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && pready |=> !pready)
    else $error("pready held longer than one cycle");
  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    pclk_en && setup && !bus.hit |=> pready && pslverr)
    else $error("unmapped access not flagged");
endmodule

// ===== core/i2cis_thresh_cmp.sv
// Purpose: Compare a FIFO level with a threshold field plus one
// Assumes: Level wider than field
// Notes: ABOVE selects at-or-above, else at-or-below
`timescale 1ns/10ps
module i2cis_thresh_cmp #(
  parameter int LW = 5,
  parameter int TW = 4,
  parameter bit ABOVE = 1'b1
) (
  input logic [LW-1:0] level,
  input logic [TW-1:0] field,
  output logic hit
);
  logic [LW-1:0] thr;
  assign thr = LW'(field) + LW'(1);
  assign hit = ABOVE ? (level >= thr) : (level <= thr);
endmodule

// ===== core/i2cis_irq_status.sv
// Purpose: Raw/masked interrupt flags, FIFO thresholds, read-to-clear
// Assumes: Event inputs are one-cycle pulses on pclk
// Notes: Activity levels and FIFO levels come from the protocol engine
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`include "i2cis_regs.svh"
module i2cis_irq_status #(
  parameter int DEPTH = 16,
  parameter int ABW = 16
) (
  input logic pclk,
  input logic presetn,
  input logic pclk_en,
  input logic psel,
  input logic penable,
  input logic pwrite,
  input logic [7:0] paddr,
  input logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input logic ctrl_enable,
  input logic mst_active,
  input logic slv_active,
  input logic evt_broadcast_addr_flag,
  input logic evt_start,
  input logic evt_stop,
  input logic evt_activity,
  input logic evt_rx_done,
  input logic evt_tx_abort,
  input logic [ABW-1:0] abort_src,
  input logic evt_rd_req,
  input logic tx_push,
  input logic rx_push,
  input logic rx_pop,
  input i2cis_pkg::i2cis_level_t tx_level,
  input i2cis_pkg::i2cis_level_t rx_level,
  output logic irq_out,
  output logic fifo_flush,
  output logic tx_fifo_hold,
  output logic rx_fifo_hold,
  output logic scl_hold_low
);
  import i2cis_pkg::*;

  localparam int LW = $bits(i2cis_level_t);

  i2cis_bus_if bus ();

  i2cis_apb_front u_front (
    .pclk(pclk),
    .presetn(presetn),
    .pclk_en(pclk_en),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .bus(bus)
  );

  function automatic logic at(input logic [7:0] a, input logic [7:0] o);
    return a == o;
  endfunction

  function automatic logic [3:0] sat_tl(input logic [31:0] v);
    if (v > 32'(`I2CIS_TL_MAX)) begin
      return `I2CIS_TL_MAX;
    end
    return v[3:0];
  endfunction

  i2cis_flags_t flags_r;
  i2cis_flags_t mask_r;
  i2cis_flags_t set_c;
  i2cis_flags_t clr_c;
  i2cis_state_t state_r;
  i2cis_state_t state_nxt;
  logic [3:0] rx_trigger_field_r;
  logic [3:0] tx_trigger_field_r;
  logic [ABW-1:0] abort_cause_r;
  logic active;
  logic rd_acc;
  logic wr_acc;
  logic clr_all;
  logic tx_hit;
  logic rx_hit;
  logic tx_empty_nxt;
  logic rx_full_nxt;
  logic [31:0] rdata_c;
  logic hit_c;

  assign active = mst_active | slv_active;
  assign rd_acc = bus.acc & ~bus.wr;
  assign wr_acc = bus.acc & bus.wr;
  assign clr_all = rd_acc & at(bus.addr, `I2CIS_OFS_CLR_ALL);

  i2cis_thresh_cmp #(
    .LW(LW),
    .TW(4),
    .ABOVE(1'b0)
  ) u_tx_cmp (
    .level(tx_level),
    .field(tx_trigger_field_r),
    .hit(tx_hit)
  );

  i2cis_thresh_cmp #(
    .LW(LW),
    .TW(4),
    .ABOVE(1'b1)
  ) u_rx_cmp (
    .level(rx_level),
    .field(rx_trigger_field_r),
    .hit(rx_hit)
  );

  // Disable tracking: drain while engine still busy
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      ST_RUN: begin
        if (!ctrl_enable) begin
          state_nxt = active ? ST_DRAIN : ST_OFF;
        end
      end
      ST_DRAIN: begin
        if (ctrl_enable) begin
          state_nxt = ST_RUN;
        end else if (!active) begin
          state_nxt = ST_OFF;
        end
      end
      ST_OFF: begin
        if (ctrl_enable) begin
          state_nxt = ST_RUN;
        end
      end
      default: begin
        state_nxt = ST_OFF;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= ST_OFF;
    end else if (pclk_en) begin
      state_r <= state_nxt;
    end
  end

  // Set events
  always_comb begin
    set_c = '0;
    set_c[`I2CIS_B_GC] = evt_broadcast_addr_flag;
    set_c[`I2CIS_B_STA] = evt_start;
    set_c[`I2CIS_B_STP] = evt_stop;
    set_c[`I2CIS_B_ACT] = evt_activity | active;
    set_c[`I2CIS_B_RXD] = evt_rx_done;
    set_c[`I2CIS_B_ABT] = evt_tx_abort;
    set_c[`I2CIS_B_RDR] = evt_rd_req;
    set_c[`I2CIS_B_TXO] = tx_push & (tx_level == LW'(DEPTH));
    set_c[`I2CIS_B_RXO] = rx_push & (rx_level == LW'(DEPTH));
    set_c[`I2CIS_B_RXU] = rx_pop & (rx_level == '0);
  end

  // Clear sources: reads, disable, drain finished
  always_comb begin
    clr_c = '0;
    clr_c[`I2CIS_B_GC] = clr_all | ~ctrl_enable
      | (rd_acc & at(bus.addr, `I2CIS_OFS_CLR_GC));
    clr_c[`I2CIS_B_STA] = clr_all
      | (rd_acc & at(bus.addr, `I2CIS_OFS_CLR_STA));
    clr_c[`I2CIS_B_STP] = clr_all
      | (rd_acc & at(bus.addr, `I2CIS_OFS_CLR_STP));
    clr_c[`I2CIS_B_ACT] = clr_all | ~ctrl_enable
      | (rd_acc & at(bus.addr, `I2CIS_OFS_CLR_ACT));
    clr_c[`I2CIS_B_RXD] = clr_all
      | (rd_acc & at(bus.addr, `I2CIS_OFS_CLR_RXD));
    clr_c[`I2CIS_B_ABT] = clr_all
      | (rd_acc & at(bus.addr, `I2CIS_OFS_CLR_ABT));
    clr_c[`I2CIS_B_RDR] = clr_all
      | (rd_acc & at(bus.addr, `I2CIS_OFS_CLR_RDR));
    clr_c[`I2CIS_B_TXO] = clr_all | (state_r == ST_OFF)
      | (rd_acc & at(bus.addr, `I2CIS_OFS_CLR_TXO));
    clr_c[`I2CIS_B_RXO] = clr_all | (state_r == ST_OFF)
      | (rd_acc & at(bus.addr, `I2CIS_OFS_CLR_RXO));
    clr_c[`I2CIS_B_RXU] = clr_all | (state_r == ST_OFF)
      | (rd_acc & at(bus.addr, `I2CIS_OFS_CLR_RXU));
  end

  // Level flags follow thresholds while enabled (TXE tracks activity, RXF is zero when disabled), untouched by clear reads
  assign tx_empty_nxt = ctrl_enable ? tx_hit : active;
  assign rx_full_nxt = ctrl_enable & rx_hit;

  genvar gi;
  generate
    for (gi = 0; gi < `I2CIS_NFLAGS; gi++) begin : g_flag
      if (gi == `I2CIS_B_TXE || gi == `I2CIS_B_RXF) begin : g_lvl
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            flags_r[gi] <= 1'b0;
          end else if (pclk_en) begin
            flags_r[gi] <= (gi == `I2CIS_B_TXE) ? tx_empty_nxt
                                                : rx_full_nxt;
          end
        end
      end else begin : g_sticky
        // Set beats a clear in the same cycle
        always_ff @(posedge pclk or negedge presetn) begin
          if (!presetn) begin
            flags_r[gi] <= 1'b0;
          end else if (pclk_en) begin
            if (set_c[gi]) begin
              flags_r[gi] <= 1'b1;
            end else if (clr_c[gi]) begin
              flags_r[gi] <= 1'b0;
            end
          end
        end
      end
    end
  endgenerate

  // Abort cause accumulates until cleared
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      abort_cause_r <= '0;
    end else if (pclk_en) begin
      if (evt_tx_abort) begin
        abort_cause_r <= abort_cause_r | abort_src;
      end else if (clr_c[`I2CIS_B_ABT]) begin
        abort_cause_r <= '0;
      end
    end
  end

  // Software-written configuration
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mask_r <= `I2CIS_MASK_RST;
      rx_trigger_field_r <= `I2CIS_TL_RST;
      tx_trigger_field_r <= `I2CIS_TL_RST;
    end else if (pclk_en && wr_acc) begin
      if (at(bus.addr, `I2CIS_OFS_MASK)) begin
        mask_r <= bus.wdata[`I2CIS_NFLAGS-1:0];
      end
      if (at(bus.addr, `I2CIS_OFS_RX_TRIGGER_FIELD)) begin
        rx_trigger_field_r <= sat_tl(bus.wdata);
      end
      if (at(bus.addr, `I2CIS_OFS_TX_TRIGGER_FIELD)) begin
        tx_trigger_field_r <= sat_tl(bus.wdata);
      end
    end
  end

  // FIFO control towards the data path
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fifo_flush <= 1'b0;
      tx_fifo_hold <= 1'b1;
      rx_fifo_hold <= 1'b1;
    end else if (pclk_en) begin
      fifo_flush <= evt_tx_abort;
      tx_fifo_hold <= ~ctrl_enable;
      rx_fifo_hold <= ~ctrl_enable;
    end
  end

  // Clock stretch until software supplies the byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      scl_hold_low <= 1'b0;
    end else if (pclk_en) begin
      if (evt_rd_req) begin
        scl_hold_low <= 1'b1;
      end else if (tx_push || !ctrl_enable) begin
        scl_hold_low <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_out <= 1'b0;
    end else if (pclk_en) begin
      irq_out <= |(flags_r & mask_r);
    end
  end

  // Read mux; clear registers read as zero
  always_comb begin
    rdata_c = 32'h00000000;
    hit_c = 1'b1;
    case (bus.addr)
      `I2CIS_OFS_MASKED: rdata_c = 32'(flags_r & mask_r);
      `I2CIS_OFS_MASK: rdata_c = 32'(mask_r);
      `I2CIS_OFS_RAW: rdata_c = 32'(flags_r);
      `I2CIS_OFS_RX_TRIGGER_FIELD: rdata_c = 32'(rx_trigger_field_r);
      `I2CIS_OFS_TX_TRIGGER_FIELD: rdata_c = 32'(tx_trigger_field_r);
      `I2CIS_OFS_ABT_SRC: rdata_c = 32'(abort_cause_r);
      `I2CIS_OFS_CLR_ALL, `I2CIS_OFS_CLR_RXU, `I2CIS_OFS_CLR_RXO,
      `I2CIS_OFS_CLR_TXO, `I2CIS_OFS_CLR_RDR, `I2CIS_OFS_CLR_ABT,
      `I2CIS_OFS_CLR_RXD, `I2CIS_OFS_CLR_ACT, `I2CIS_OFS_CLR_STP,
      `I2CIS_OFS_CLR_STA, `I2CIS_OFS_CLR_GC: begin
        rdata_c = 32'h00000000;
      end
      default: begin
        hit_c = 1'b0;
      end
    endcase
  end

  assign bus.rdata = rdata_c;
  assign bus.hit = hit_c;

  a_raw_upper_zero: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && psel && !penable && !pready && !pwrite
      && paddr == `I2CIS_OFS_RAW |=> prdata[31:12] == 20'h00000)
    else $error("raw status upper bits not zero");
  a_gc_disable_clr: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && !ctrl_enable && !evt_broadcast_addr_flag |=> !flags_r[11])
    else $error("general call flag survived disable");
  a_start_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && evt_start |=> flags_r[10])
    else $error("start flag not set");
  a_stop_sets: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && evt_stop |=> flags_r[9])
    else $error("stop flag not set");
  a_activity_sticks: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && flags_r[8] && ctrl_enable && !clr_all
      && !(rd_acc && bus.addr == `I2CIS_OFS_CLR_ACT) |=> flags_r[8])
    else $error("activity flag dropped without a clear");
  a_abort_flush: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && evt_tx_abort |=> fifo_flush && flags_r[6])
    else $error("abort did not flush fifos");
  a_scl_hold: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && evt_rd_req |=> scl_hold_low && flags_r[5])
    else $error("read request did not stretch clock");
  a_tx_over_set: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && tx_push && tx_level == 5'h10 |=> flags_r[3])
    else $error("tx overflow not flagged");
  a_rx_full_off: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && !ctrl_enable |=> !flags_r[2])
    else $error("rx full set while disabled");
  a_rx_under_wins: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && rx_pop && rx_level == 5'h00 |=> flags_r[0])
    else $error("rx underflow lost");
  a_rx_trigger_field_sat: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en && wr_acc && bus.addr == `I2CIS_OFS_RX_TRIGGER_FIELD
      && bus.wdata > 32'h0000000F |=> rx_trigger_field_r == 4'hF)
    else $error("rx threshold not saturated");
  a_irq_follows: assert property (
    @(posedge pclk) disable iff (!presetn)
    pclk_en |=> irq_out == |($past(flags_r) & $past(mask_r)))
    else $error("combined irq mismatch");
endmodule

// ===== testbench/i2cis_tb.sv
// Purpose: Self-checking bench for the interrupt status block
// Assumes: One pclk domain, APB answered in one access cycle
// Notes: Read results checked by a monitor from an expectation queue
`timescale 1ns/10ps
`include "i2cis_regs.svh"
module testbench;
  import i2cis_pkg::*;
  logic pclk, presetn, pclk_en, psel, penable, pwrite;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata;
  logic pready, pslverr, ctrl_enable, mst_active, slv_active;
  logic [9:0] evt;
  logic [15:0] abort_src, rnd_st, src, w;
  i2cis_level_t tx_level, rx_level;
  logic irq_out, fifo_flush, tx_fifo_hold, rx_fifo_hold, scl_hold_low;
  logic [40:0] exp_q[$];
  logic [40:0] e;
  logic [32:0] r;
  logic [11:0] st, m;
  int error_cnt, n_checks, tt, rt, tl;
  int fbit [10] = '{11, 10, 9, 8, 7, 6, 5, 3, 1, 0};
  logic [7:0] clr_ofs [10] = '{`I2CIS_OFS_CLR_GC, `I2CIS_OFS_CLR_STA,
    `I2CIS_OFS_CLR_STP, `I2CIS_OFS_CLR_ACT, `I2CIS_OFS_CLR_RXD,
    `I2CIS_OFS_CLR_ABT, `I2CIS_OFS_CLR_RDR, `I2CIS_OFS_CLR_TXO,
    `I2CIS_OFS_CLR_RXO, `I2CIS_OFS_CLR_RXU};

  i2cis_irq_status i_dut (
    .pclk(pclk), .presetn(presetn), .pclk_en(pclk_en), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ctrl_enable(ctrl_enable), .mst_active(mst_active),
    .slv_active(slv_active), .evt_broadcast_addr_flag(evt[0]), .evt_start(evt[1]),
    .evt_stop(evt[2]), .evt_activity(evt[3]), .evt_rx_done(evt[4]),
    .evt_tx_abort(evt[5]), .abort_src(abort_src), .evt_rd_req(evt[6]),
    .tx_push(evt[7]), .rx_push(evt[8]), .rx_pop(evt[9]),
    .tx_level(tx_level), .rx_level(rx_level), .irq_out(irq_out),
    .fifo_flush(fifo_flush), .tx_fifo_hold(tx_fifo_hold),
    .rx_fifo_hold(rx_fifo_hold), .scl_hold_low(scl_hold_low)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  function logic [15:0] rnd();
    rnd_st = {rnd_st[14:0], rnd_st[15] ^ rnd_st[13] ^ rnd_st[12] ^ rnd_st[10]};
    return rnd_st;
  endfunction

  // Threshold flags expected from the levels being driven
  function logic [32:0] raw();
    logic [11:0] v;
    v = st;
    v[4] = ctrl_enable ? (int'(tx_level) <= tt + 1) : (mst_active | slv_active);
    v[2] = ctrl_enable && (int'(rx_level) >= rt + 1);
    return {21'h0, v};
  endfunction

  task chk(input string nm, input logic [32:0] seen, input logic [32:0] ex);
    n_checks++;
    if (seen !== ex) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, ex, seen);
    end
  endtask

  task idle(input int n);
    repeat (n) @(negedge pclk);
  endtask

  task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    @(negedge pclk);
    while (pready !== 1'b1 && n < 50) begin
      @(negedge pclk);
      n++;
    end
    @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
    if (n >= 50) chk("pready", 33'h0, 33'h1);
  endtask

  task rd(input logic [7:0] a, input logic [32:0] ex);
    exp_q.push_back({a, ex});
    apb(1'b0, a, 32'h0);
  endtask

  task pulse(input int i);
    @(posedge pclk);
    evt[i] <= 1'b1;
    @(posedge pclk);
    evt[i] <= 1'b0;
  endtask

  task drive(input int t, input int x, input logic en, ma, sa);
    @(posedge pclk);
    tx_level <= 5'(t);
    rx_level <= 5'(x);
    ctrl_enable <= en;
    mst_active <= ma;
    slv_active <= sa;
    abort_src <= src;
    idle(3);
  endtask

  task close_out();
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Read result monitor
  always @(negedge pclk) begin
    if (psel && penable && !pwrite && pready === 1'b1) begin
      if (exp_q.size() == 0) begin
        chk("unexpected read", 33'h1, 33'h0);
      end else begin
        e = exp_q.pop_front();
        chk($sformatf("read %h", e[40:33]), {pslverr, prdata}, e[32:0]);
      end
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    $display("watchdog expired");
    close_out();
  end

  initial begin
    {psel, penable, pwrite, paddr, pwdata, evt, abort_src} = '0;
    {mst_active, slv_active, rx_level, st, error_cnt, n_checks} = '0;
    {presetn, pclk_en, ctrl_enable, tx_level, src} = {3'h3, 5'h10, 16'h0};
    tt = 7;
    rt = 7;
    rnd_st = 16'h401B;
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    idle(2);
    rd(`I2CIS_OFS_RAW, raw());
    rd(`I2CIS_OFS_RX_TRIGGER_FIELD, 33'h7);
    rd(`I2CIS_OFS_TX_TRIGGER_FIELD, 33'h7);
    rd(`I2CIS_OFS_MASK, 33'h8FF);
    rd(`I2CIS_OFS_CLR_ALL, 33'h0);
    rd(8'h90, {1'b1, 32'h0});
    apb(1'b1, `I2CIS_OFS_RAW, 32'hFFFFFFFF);
    rd(`I2CIS_OFS_RAW, raw());
    $display("reset test done");
    for (int i = 0; i < 10; i++) begin
      src = rnd();
      drive(16, (i == 9) ? 0 : 16, 1'b1, 1'b0, 1'b0);
      pulse(i);
      @(negedge pclk);
      if (i == 5) chk("fifo_flush", fifo_flush, 33'h1);
      idle(2);
      if (i == 6) chk("scl hold", scl_hold_low, 33'h1);
      if (i == 7) chk("scl release", scl_hold_low, 33'h0);
      st[fbit[i]] = 1'b1;
      rd(`I2CIS_OFS_RAW, raw());
      if (i == 5) rd(`I2CIS_OFS_ABT_SRC, {17'h0, src});
      st[fbit[i]] = 1'b0;
      rd(clr_ofs[i], 33'h0);
      rd(`I2CIS_OFS_RAW, raw());
    end
    $display("flag test done");
    src = rnd();
    drive(16, 16, 1'b1, 1'b0, 1'b0);
    for (int i = 1; i < 8; i += 2) pulse((i < 5) ? (i + 1) / 2 : i);
    st = 12'h658;
    idle(2);
    rd(`I2CIS_OFS_RAW, raw());
    rd(`I2CIS_OFS_ABT_SRC, {17'h0, src});
    rd(`I2CIS_OFS_CLR_ALL, 33'h0);
    st = 12'h0;
    rd(`I2CIS_OFS_RAW, raw());
    rd(`I2CIS_OFS_ABT_SRC, 33'h0);
    $display("clear all test done");
    pulse(1);
    pulse(2);
    st = 12'h600;
    for (int k = 0; k < 4; k++) begin
      w = rnd();
      m = (k == 0) ? 12'h0 : ((k == 3) ? 12'hFFF : w[11:0]);
      apb(1'b1, `I2CIS_OFS_MASK, {20'h0, m});
      r = raw();
      rd(`I2CIS_OFS_MASKED, {21'h0, m & r[11:0]});
      idle(2);
      chk("irq_out", irq_out, {32'h0, |(m & r[11:0])});
    end
    rd(`I2CIS_OFS_CLR_ALL, 33'h0);
    st = 12'h0;
    $display("mask test done");
    for (int k = 0; k < 8; k++) begin
      w = rnd();
      if (k < 2) w[9:0] = (k == 0) ? 10'h0 : 10'h3FF;
      apb(1'b1, `I2CIS_OFS_TX_TRIGGER_FIELD, {27'h0, w[4:0]});
      apb(1'b1, `I2CIS_OFS_RX_TRIGGER_FIELD, {27'h0, w[9:5]});
      tt = (w[4:0] > 15) ? 15 : int'(w[4:0]);
      rt = (w[9:5] > 15) ? 15 : int'(w[9:5]);
      rd(`I2CIS_OFS_TX_TRIGGER_FIELD, 33'(tt));
      rd(`I2CIS_OFS_RX_TRIGGER_FIELD, 33'(rt));
      tl = tt + 1 + int'(w[10]);
      drive((tl > 16) ? 16 : tl, rt + int'(w[11]), 1'b1, 1'b0, 1'b0);
      rd(`I2CIS_OFS_RAW, raw());
    end
    $display("threshold test done");
    drive(16, 0, 1'b1, 1'b0, 1'b0);
    pulse(9);
    drive(16, 16, 1'b1, 1'b0, 1'b0);
    for (int i = 0; i < 9; i += 3) pulse((i == 6) ? 8 : i);
    pulse(7);
    st = 12'h90B;
    drive(16, 16, 1'b0, 1'b1, 1'b0);
    chk("tx hold", tx_fifo_hold, 33'h1);
    chk("rx hold", rx_fifo_hold, 33'h1);
    st = 12'h10B;
    rd(`I2CIS_OFS_RAW, raw());
    drive(16, 16, 1'b0, 1'b0, 1'b1);
    rd(`I2CIS_OFS_RAW, raw());
    drive(16, 16, 1'b0, 1'b0, 1'b0);
    st = 12'h0;
    rd(`I2CIS_OFS_RAW, raw());
    drive(16, 0, 1'b1, 1'b0, 1'b0);
    $display("disable test done");
    idle(4);
    chk("queue left", 33'(exp_q.size()), 33'h0);
    close_out();
  end
endmodule
